//--- logic/data_space_pkg.sv
/*
 data space decoder package: address map, I/O offsets, eeprom control layout,
 timing counts and the carrier structs shared by the decoder and its eeprom unit.
 assumes a single 250 MHz cpu clock.
*/
`default_nettype none
package data_space_pkg;

   localparam logic [15:0] REG_FILE_LAST  = 16'h001f;
   localparam logic [15:0] STD_IO_FIRST   = 16'h0020;
   localparam logic [15:0] STD_IO_LAST    = 16'h005f;
   localparam logic [15:0] EXT_IO_FIRST   = 16'h0060;
   localparam logic [15:0] EXT_IO_LAST    = 16'h00ff;
   localparam logic [15:0] SRAM_FIRST     = 16'h0100;
   localparam logic [15:0] SRAM_BYTES     = 16'h0400;
   localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
   localparam logic [5:0]  IO_BIT_LAST    = 6'h1f;

   // pointer pair low registers
   localparam logic [4:0] PTR_X_LO = 5'h1a;
   localparam logic [4:0] PTR_Y_LO = 5'h1c;
   localparam logic [4:0] PTR_Z_LO = 5'h1e;

   // I/O addresses of the blocks held here
   localparam logic [5:0] IO_GPR0    = 6'h1e;
   localparam logic [5:0] IO_GPR1    = 6'h2a;
   localparam logic [5:0] IO_GPR2    = 6'h2b;
   localparam logic [5:0] IO_NVM_CTL = 6'h1f;
   localparam logic [5:0] IO_NVM_DAT = 6'h20;
   localparam logic [5:0] IO_NVM_ADL = 6'h21;
   localparam logic [5:0] IO_NVM_ADH = 6'h22;
   localparam logic [5:0] IO_FLAGS   = 6'h1d;

   // nvm control bit positions
   localparam int CTL_READ   = 0;
   localparam int CTL_STROBE = 1;
   localparam int CTL_MASTER = 2;
   localparam int CTL_RDYIE  = 3;
   localparam int CTL_MODE0  = 4;
   localparam int CTL_MODE1  = 5;
   localparam logic [7:0] CTL_RW_MASK = 8'h3f;

   localparam logic [2:0]  READ_STALL_CYC  = 3'h4;
   localparam logic [2:0]  WRITE_STALL_CYC = 3'h2;
   localparam logic [2:0]  MASTER_WIN_CYC  = 3'h4;
   localparam int          SRAM_ACC_CYC    = 2;
   localparam logic [10:0] NVM_BYTES       = 11'h400;

   // programming times in microseconds, and cycles at 250 MHz
   localparam int CLK_MHZ        = 250;
   localparam int T_ATOMIC_US    = 3400;
   localparam int T_HALF_US      = 1800;
   localparam int ATOMIC_CYC     = T_ATOMIC_US * CLK_MHZ;
   localparam int HALF_CYC       = T_HALF_US * CLK_MHZ;

   typedef enum logic [1:0] {
      MODE_DIRECT = 2'h0,
      MODE_PREDEC = 2'h1,
      MODE_POSTINC = 2'h2,
      MODE_DISP   = 2'h3
   } addr_mode_type;

   typedef enum logic [1:0] {
      PTR_X = 2'h0,
      PTR_Y = 2'h1,
      PTR_Z = 2'h2,
      PTR_NONE = 2'h3
   } ptr_sel_type;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_MEM_READ = 3'h1,
      OP_MEM_WRITE = 3'h2,
      OP_IO_READ = 3'h3,
      OP_IO_WRITE = 3'h4,
      OP_SET_BIT = 3'h5,
      OP_CLEAR_BIT = 3'h6,
      OP_SKIP_TEST = 3'h7
   } op_type;

   typedef struct packed {
      op_type        op;
      addr_mode_type mode;
      ptr_sel_type   ptr;
      logic [15:0]   addr;
      logic [5:0]    disp;
      logic [2:0]    bit_idx;
      logic [7:0]    wdata;
   } cpu_req_type;

   typedef struct packed {
      logic        ready;
      logic [7:0]  rdata;
      logic        skip_if_bit_set;
      logic        bit_value;
      logic        stall;
   } cpu_rsp_type;

   typedef struct packed {
      logic        we;
      logic [5:0]  io_addr;
      logic [7:0]  wdata;
   } io_wr_type;

endpackage : data_space_pkg
`default_nettype wire

//--- logic/nvm_access_unit.sv
/*
 nvm access unit: address, data and control registers of the eeprom, the
 timed write-enable window, self-timed programming and cpu stall counts.
 assumes an external byte-wide nvm array with a one-cycle read port.
*/
`timescale 1ns/10ps
`default_nettype none
module nvm_access_unit #(
   parameter int ATOMIC_CYC = data_space_pkg::ATOMIC_CYC,
   parameter int HALF_CYC   = data_space_pkg::HALF_CYC
) (
   input  wire logic                      mclk_i,
   input  wire logic                      srst_i,
   input  wire data_space_pkg::io_wr_type io_wr_i,
   output logic [7:0]                     ctl_o,
   output logic [7:0]                     dat_o,
   output logic [9:0]                     adr_o,
   output logic                           stall_o,
   output logic                           nvm_rd_o,
   output logic                           nvm_wr_o,
   output logic [1:0]                     nvm_mode_o,
   input  wire logic [7:0]                nvm_rdata_i
);
   logic [7:0]  dat_r;
   logic [9:0]  adr_r;
   logic [1:0]  mode_r;
   logic        rdyie_r;
   logic        master_r;
   logic        strobe_r;
   logic [2:0]  master_cnt_r;
   logic [2:0]  stall_cnt_r;
   logic [31:0] prog_cnt_r;
   logic        ctl_wr;
   logic        start_wr;
   logic        start_rd;
   logic        prog_done;

   assign ctl_wr    = io_wr_i.we && io_wr_i.io_addr == data_space_pkg::IO_NVM_CTL;
   assign start_wr  = ctl_wr && io_wr_i.wdata[data_space_pkg::CTL_STROBE] && master_r
                      && !strobe_r && mode_r != 2'h3;
   assign start_rd  = ctl_wr && io_wr_i.wdata[data_space_pkg::CTL_READ] && !strobe_r;
   assign prog_done = strobe_r && prog_cnt_r == 32'h0000_0001;

   // self-timed programming; reset does not abort it
   always_ff @(posedge mclk_i) begin
      if (start_wr) begin
         strobe_r   <= 1'b1;
         prog_cnt_r <= (mode_r == 2'h0) ? 32'(ATOMIC_CYC) : 32'(HALF_CYC);
      end else if (prog_done) begin
         strobe_r   <= 1'b0;
         prog_cnt_r <= 32'h0;
      end else if (strobe_r) begin
         prog_cnt_r <= prog_cnt_r - 32'h1;
      end else if (srst_i) begin
         strobe_r   <= 1'b0;
         prog_cnt_r <= 32'h0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         master_r     <= 1'b0;
         master_cnt_r <= 3'h0;
      end else if (ctl_wr && io_wr_i.wdata[data_space_pkg::CTL_MASTER]
                   && !io_wr_i.wdata[data_space_pkg::CTL_STROBE]) begin
         master_r     <= 1'b1;
         master_cnt_r <= data_space_pkg::MASTER_WIN_CYC;
      end else if (master_cnt_r == 3'h1 || start_wr) begin
         master_r     <= 1'b0;
         master_cnt_r <= 3'h0;
      end else if (master_cnt_r != 3'h0) begin
         master_cnt_r <= master_cnt_r - 3'h1;
      end
   end

   // mode locked while programming, through reset too; address locked against writes only, reset still clears it
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rdyie_r <= 1'b0;
         if (!strobe_r) mode_r <= 2'h0;
      end else if (ctl_wr) begin
         rdyie_r <= io_wr_i.wdata[data_space_pkg::CTL_RDYIE];
         if (!strobe_r) mode_r <= io_wr_i.wdata[data_space_pkg::CTL_MODE1:data_space_pkg::CTL_MODE0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         adr_r <= 10'h0;
         dat_r <= 8'h00;
      end else begin
         if (io_wr_i.we && !strobe_r && io_wr_i.io_addr == data_space_pkg::IO_NVM_ADL)
            adr_r[7:0] <= io_wr_i.wdata;
         if (io_wr_i.we && !strobe_r && io_wr_i.io_addr == data_space_pkg::IO_NVM_ADH)
            adr_r[9:8] <= io_wr_i.wdata[1:0];
         if (start_rd)
            dat_r <= nvm_rdata_i;
         else if (io_wr_i.we && io_wr_i.io_addr == data_space_pkg::IO_NVM_DAT)
            dat_r <= io_wr_i.wdata;
      end
   end

   // cpu halt after nvm read or write start
   always_ff @(posedge mclk_i) begin
      if (srst_i)
         stall_cnt_r <= 3'h0;
      else if (start_rd)
         stall_cnt_r <= data_space_pkg::READ_STALL_CYC;
      else if (start_wr)
         stall_cnt_r <= data_space_pkg::WRITE_STALL_CYC;
      else if (stall_cnt_r != 3'h0)
         stall_cnt_r <= stall_cnt_r - 3'h1;
   end

   assign stall_o    = stall_cnt_r != 3'h0;
   assign nvm_rd_o   = start_rd;
   assign nvm_wr_o   = start_wr;
   assign nvm_mode_o = mode_r;
   assign adr_o      = adr_r;
   assign dat_o      = dat_r;
   assign ctl_o      = {2'h0, mode_r, rdyie_r, master_r, strobe_r, 1'b0};
endmodule : nvm_access_unit
`default_nettype wire

//--- logic/data_space_decoder.sv
/*
 data space decoder: routes cpu load, store, I/O and bit operations to the
 register file, standard and extended I/O, internal sram and the nvm unit.
 assumes the cpu holds a request until ready and honours stall.
 peripheral registers outside this block sit behind the I/O port pair.
*/
`timescale 1ns/10ps
`default_nettype none
module data_space_decoder #(
   parameter int ATOMIC_CYC = data_space_pkg::ATOMIC_CYC,
   parameter int HALF_CYC   = data_space_pkg::HALF_CYC,
   parameter logic [15:0] SRAM_SIZE = data_space_pkg::SRAM_BYTES
) (
   input  wire logic                        mclk_i,
   input  wire logic                        srst_i,
   input  wire logic                        req_valid_i,
   input  wire data_space_pkg::cpu_req_type req_i,
   output data_space_pkg::cpu_rsp_type      rsp_o,
   input  wire logic [7:0]                  flag_set_i,
   output logic [7:0]                       flags_o,
   output logic                             periph_we_o,
   output logic                             periph_re_o,
   output logic [7:0]                       periph_addr_o,
   output logic [7:0]                       periph_wdata_o,
   input  wire logic [7:0]                  periph_rdata_i,
   output logic                             nvm_rd_o,
   output logic                             nvm_wr_o,
   output logic [1:0]                       nvm_mode_o,
   output logic [9:0]                       nvm_addr_o,
   output logic [7:0]                       nvm_wdata_o,
   input  wire logic [7:0]                  nvm_rdata_i
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SRAM = 2'b01,
      ST_DONE = 2'b11
   } acc_state_type;

   acc_state_type state_r;
   acc_state_type state_nxt;
   logic [7:0]  regfile_r [32];
   logic [7:0]  sram_r [1024];
   logic [7:0]  gpr_r [3];
   logic [7:0]  flags_r;
   logic [7:0]  rdata_r;
   logic        skip_r;
   logic [15:0] base;
   logic [15:0] eff;
   logic [15:0] ptr_new;
   logic [4:0]  ptr_lo;
   logic [5:0]  io_a;
   logic        is_data;
   logic        is_bitop;
   logic        in_rf;
   logic        in_std;
   logic        in_ext;
   logic        in_sram;
   logic        bit_ok;
   logic        wr_acc;
   logic        go;
   logic [7:0]  io_old;
   logic [7:0]  io_wval;
   logic [7:0]  rd_val;
   logic [7:0]  nvm_ctl;
   logic [7:0]  nvm_dat;
   logic [9:0]  nvm_adr;
   logic        nvm_stall;
   data_space_pkg::io_wr_type io_wr;

   assign is_data  = req_i.op == data_space_pkg::OP_MEM_READ
                     || req_i.op == data_space_pkg::OP_MEM_WRITE;
   assign is_bitop = req_i.op == data_space_pkg::OP_SET_BIT
                     || req_i.op == data_space_pkg::OP_CLEAR_BIT
                     || req_i.op == data_space_pkg::OP_SKIP_TEST;

   // pointer base and effective address
   always_comb begin
      case (req_i.ptr)
         data_space_pkg::PTR_X: ptr_lo = data_space_pkg::PTR_X_LO;
         data_space_pkg::PTR_Y: ptr_lo = data_space_pkg::PTR_Y_LO;
         data_space_pkg::PTR_Z: ptr_lo = data_space_pkg::PTR_Z_LO;
         default:               ptr_lo = 5'h00;
      endcase
      base = {regfile_r[ptr_lo + 5'h1], regfile_r[ptr_lo]};
      case (req_i.mode)
         data_space_pkg::MODE_PREDEC:  ptr_new = base - 16'h1;
         data_space_pkg::MODE_POSTINC: ptr_new = base + 16'h1;
         default:                      ptr_new = base;
      endcase
      case (req_i.mode)
         data_space_pkg::MODE_DIRECT: eff = req_i.addr;
         data_space_pkg::MODE_PREDEC: eff = ptr_new;
         data_space_pkg::MODE_DISP:   eff = base + {10'h0, req_i.disp};
         default:                     eff = base;
      endcase
      if (!is_data)
         eff = {10'h0, req_i.addr[5:0]} + data_space_pkg::IO_DATA_OFFSET;
   end

   assign in_rf   = eff <= data_space_pkg::REG_FILE_LAST;
   assign in_std  = eff >= data_space_pkg::STD_IO_FIRST
                    && eff <= data_space_pkg::STD_IO_LAST;
   assign in_ext  = is_data && eff >= data_space_pkg::EXT_IO_FIRST
                    && eff <= data_space_pkg::EXT_IO_LAST;
   assign in_sram = is_data && eff >= data_space_pkg::SRAM_FIRST
                    && eff < data_space_pkg::SRAM_FIRST + SRAM_SIZE;
   assign io_a    = 6'(eff - data_space_pkg::IO_DATA_OFFSET);
   assign bit_ok  = !is_bitop || req_i.addr[5:0] <= data_space_pkg::IO_BIT_LAST;
   assign wr_acc  = req_i.op == data_space_pkg::OP_MEM_WRITE
                    || req_i.op == data_space_pkg::OP_IO_WRITE
                    || req_i.op == data_space_pkg::OP_SET_BIT
                    || req_i.op == data_space_pkg::OP_CLEAR_BIT;
   assign go      = req_valid_i && state_r == ST_IDLE && !nvm_stall;

   // own registers exist in standard I/O only; io_a aliases for extended addresses
   logic own_io;
   assign own_io = in_std && io_a inside {data_space_pkg::IO_GPR0, data_space_pkg::IO_GPR1,
                   data_space_pkg::IO_GPR2, data_space_pkg::IO_FLAGS,
                   data_space_pkg::IO_NVM_CTL, data_space_pkg::IO_NVM_DAT,
                   data_space_pkg::IO_NVM_ADL, data_space_pkg::IO_NVM_ADH};

   // old value of the addressed I/O location
   always_comb begin
      io_old = 8'h00;
      if (io_a == data_space_pkg::IO_GPR0) io_old = gpr_r[0];
      if (io_a == data_space_pkg::IO_GPR1) io_old = gpr_r[1];
      if (io_a == data_space_pkg::IO_GPR2) io_old = gpr_r[2];
      if (io_a == data_space_pkg::IO_FLAGS) io_old = flags_r;
      if (io_a == data_space_pkg::IO_NVM_CTL) io_old = nvm_ctl;
      if (io_a == data_space_pkg::IO_NVM_DAT) io_old = nvm_dat;
      if (io_a == data_space_pkg::IO_NVM_ADL) io_old = nvm_adr[7:0];
      if (io_a == data_space_pkg::IO_NVM_ADH) io_old = {6'h0, nvm_adr[9:8]};
      if (!own_io) io_old = periph_rdata_i;
   end

   // value written; bit ops write back the old value with bit_idx set or cleared
   always_comb begin
      io_wval = req_i.wdata;
      if (req_i.op == data_space_pkg::OP_SET_BIT || req_i.op == data_space_pkg::OP_CLEAR_BIT) begin
         io_wval = io_old;
         io_wval[req_i.bit_idx] = req_i.op == data_space_pkg::OP_SET_BIT;
      end
   end

   logic io_fire;
   logic bit_fire;
   assign io_fire  = go && bit_ok && (in_std || in_ext) && !in_sram;
   assign bit_fire = io_fire && (req_i.op == data_space_pkg::OP_SET_BIT
                     || req_i.op == data_space_pkg::OP_CLEAR_BIT);

   assign io_wr.we      = io_fire && wr_acc && in_std;
   assign io_wr.io_addr = io_a;
   assign io_wr.wdata   = io_wval;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (go && in_sram) state_nxt = ST_SRAM;
         ST_SRAM: state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) state_r <= ST_IDLE;
      else        state_r <= state_nxt;
   end

   // working registers and pointer write-back
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         for (int i = 0; i < 32; i++) regfile_r[i] <= 8'h00;
      end else begin
         if (go && in_rf && is_data && req_i.op == data_space_pkg::OP_MEM_WRITE)
            regfile_r[eff[4:0]] <= req_i.wdata;
         // pointer moves only once the access is done with it
         if (req_valid_i && rsp_o.ready && is_data && (req_i.mode == data_space_pkg::MODE_PREDEC
             || req_i.mode == data_space_pkg::MODE_POSTINC)) begin
            regfile_r[ptr_lo]        <= ptr_new[7:0];
            regfile_r[ptr_lo + 5'h1] <= ptr_new[15:8];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (state_r == ST_SRAM && req_i.op == data_space_pkg::OP_MEM_WRITE)
         sram_r[10'(eff - data_space_pkg::SRAM_FIRST)] <= req_i.wdata;
   end

   // general purpose I/O registers
   generate
      for (genvar g = 0; g < 3; g++) begin : gpr_g
         localparam logic [5:0] GA = g == 0 ? data_space_pkg::IO_GPR0
                                   : g == 1 ? data_space_pkg::IO_GPR1 : data_space_pkg::IO_GPR2;
         always_ff @(posedge mclk_i) begin
            if (srst_i) gpr_r[g] <= 8'h00;
            else if (io_wr.we && io_a == GA) gpr_r[g] <= io_wval;
         end
      end
   endgenerate

   // write-one-to-clear flags; a new event wins over the clear
   always_ff @(posedge mclk_i) begin
      if (srst_i)
         flags_r <= 8'h00;
      else if (io_wr.we && io_a == data_space_pkg::IO_FLAGS)
         flags_r <= (flags_r & ~(bit_fire ? 8'h00 : req_i.wdata)) | flag_set_i;
      else
         flags_r <= flags_r | flag_set_i;
   end

   always_comb begin
      rd_val = 8'h00;
      if (in_rf && is_data) rd_val = regfile_r[eff[4:0]];
      else if (in_std || in_ext) rd_val = io_old;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rdata_r <= 8'h00;
         skip_r  <= 1'b0;
      end else if (state_r == ST_SRAM) begin
         rdata_r <= sram_r[10'(eff - data_space_pkg::SRAM_FIRST)];
      end else if (go) begin
         rdata_r <= bit_ok ? rd_val : 8'h00;
         skip_r  <= req_i.op == data_space_pkg::OP_SKIP_TEST && bit_ok
                    && io_old[req_i.bit_idx];
      end
   end

   nvm_access_unit #(
      .ATOMIC_CYC (ATOMIC_CYC),
      .HALF_CYC   (HALF_CYC)
   ) i_nvm_access_unit (
      .mclk_i      (mclk_i),
      .srst_i      (srst_i),
      .io_wr_i     (io_wr),
      .ctl_o       (nvm_ctl),
      .dat_o       (nvm_dat),
      .adr_o       (nvm_adr),
      .stall_o     (nvm_stall),
      .nvm_rd_o    (nvm_rd_o),
      .nvm_wr_o    (nvm_wr_o),
      .nvm_mode_o  (nvm_mode_o),
      .nvm_rdata_i (nvm_rdata_i)
   );

   assign periph_we_o    = io_fire && wr_acc && !own_io;
   assign periph_re_o    = io_fire && !wr_acc && !own_io;
   assign periph_addr_o  = eff[7:0];
   assign periph_wdata_o = io_wval;
   assign nvm_addr_o     = nvm_adr;
   assign nvm_wdata_o    = nvm_dat;
   assign flags_o        = flags_r;

   assign rsp_o.ready = state_r == ST_DONE
                        || (req_valid_i && state_r == ST_IDLE && !nvm_stall && !in_sram);
   assign rsp_o.rdata           = rdata_r;
   assign rsp_o.skip_if_bit_set = skip_r;
   assign rsp_o.bit_value       = skip_r;
   assign rsp_o.stall           = nvm_stall;
endmodule : data_space_decoder
`default_nettype wire

//--- tb/data_space_monitor.sv
/* port checker for the data space decoder
   bound into every decoder instance, one clock domain */
`timescale 1ns/10ps
`default_nettype none
module data_space_monitor #(
   parameter logic [15:0] SRAM_SIZE = 16'h0400
) (
   input wire logic                        mclk_i,
   input wire logic                        srst_i,
   input wire logic                        req_valid_i,
   input wire data_space_pkg::cpu_req_type req_i,
   input wire data_space_pkg::cpu_rsp_type rsp_o,
   input wire logic [7:0]                  flag_set_i,
   input wire logic [7:0]                  flags_o,
   input wire logic                        periph_we_o,
   input wire logic [7:0]                  periph_addr_o,
   input wire logic                        nvm_rd_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);
   logic sram_rd;
   logic bit_op;
   assign sram_rd = req_valid_i && !rsp_o.stall && req_i.mode == data_space_pkg::MODE_DIRECT
      && req_i.op == data_space_pkg::OP_MEM_READ && req_i.addr >= 16'h0100
      && req_i.addr < 16'h0100 + SRAM_SIZE;
   assign bit_op = req_i.op == data_space_pkg::OP_SET_BIT || req_i.op == data_space_pkg::OP_CLEAR_BIT;
   stall_holds_a: assert property (rsp_o.stall |-> !rsp_o.ready)
      else $error("ready while stalled");
   sram_two_cyc_a: assert property ($rose(sram_rd) |-> !rsp_o.ready ##1 !rsp_o.ready ##1 rsp_o.ready)
      else $error("sram ready not two cycles after request");
   periph_range_a: assert property (periph_we_o |-> req_valid_i && periph_addr_o >= 8'h20)
      else $error("peripheral write outside I/O space");
   port_reach_a: assert property (periph_we_o && req_i.op == data_space_pkg::OP_IO_WRITE |-> periph_addr_o <= 8'h5f)
      else $error("port write reached extended I/O");
   bit_range_a: assert property (req_valid_i && bit_op && req_i.addr[5:0] > 6'h1f |-> !periph_we_o)
      else $error("bit operation above 0x1f wrote");
   flag_set_a: assert property (|flag_set_i |=> (flags_o & $past(flag_set_i)) == $past(flag_set_i))
      else $error("flag event lost");
   read_stall_a: assert property (nvm_rd_o |-> ##[0:1] rsp_o.stall)
      else $error("no stall after nvm read");
   stall_ends_a: assert property ($rose(rsp_o.stall) |-> ##[1:4] !rsp_o.stall)
      else $error("stall too long");
   sram_read_c: cover property (sram_rd ##2 rsp_o.ready);
   nvm_read_c: cover property (nvm_rd_o);
   flag_held_c: cover property (|flags_o);
endmodule : data_space_monitor
bind data_space_decoder data_space_monitor #(.SRAM_SIZE(SRAM_SIZE)) i_data_space_monitor (
   .mclk_i(mclk_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_i(req_i), .rsp_o(rsp_o),
   .flag_set_i(flag_set_i), .flags_o(flags_o), .periph_we_o(periph_we_o),
   .periph_addr_o(periph_addr_o), .nvm_rd_o(nvm_rd_o));
`default_nettype wire

//--- tb/cpu_core_model.sv
/* cpu core model: one request at a time through access()
   assumes ready is sampled at the rising edge */
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
   input  wire logic                        mclk_i,
   output logic                             req_valid_o,
   output data_space_pkg::cpu_req_type      req_o,
   input  wire data_space_pkg::cpu_rsp_type rsp_i
);
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   // held until ready, results taken one edge later
   task automatic access(input data_space_pkg::cpu_req_type r, output logic [7:0] rd,
                         output logic bv);
      int n;
      n = 0;
      @(posedge mclk_i);
      while (rsp_i.stall !== 1'b0 && n < 50) begin
         @(posedge mclk_i);
         n++;
      end
      req_valid_o <= 1'b1;
      req_o <= r;
      do begin
         @(posedge mclk_i);
         n++;
      end while (rsp_i.ready !== 1'b1 && n < 60);
      req_valid_o <= 1'b0;
      req_o <= ~r;
      @(posedge mclk_i);
      rd = rsp_i.rdata;
      bv = rsp_i.bit_value;
   endtask : access
endmodule : cpu_core_model
`default_nettype wire

//--- tb/data_space_decoder_tb.sv
/* self-checking bench for the data space decoder
   short programming counts, peripheral and nvm reads stubbed */
`timescale 1ns/10ps
`default_nettype none
module data_space_decoder_tb;
   logic                        clk, srst, req_valid, pwe, nwr, nwr_seen, bv;
   logic [7:0]                  flag_set, flags, pa, last_pa, rd, nwd;
   logic [9:0]                  nadr;
   data_space_pkg::cpu_req_type req;
   data_space_pkg::cpu_rsp_type rsp;
   int                          failures, samples_checked, cyc, stall_cyc;
   data_space_decoder #(.ATOMIC_CYC(20), .HALF_CYC(10)) i_data_space_decoder (
      .mclk_i(clk), .srst_i(srst), .req_valid_i(req_valid), .req_i(req), .rsp_o(rsp),
      .flag_set_i(flag_set), .flags_o(flags), .periph_we_o(pwe), .periph_re_o(),
      .periph_addr_o(pa), .periph_wdata_o(), .periph_rdata_i(pa ^ 8'hc3), .nvm_rd_o(),
      .nvm_wr_o(nwr), .nvm_mode_o(), .nvm_addr_o(nadr), .nvm_wdata_o(nwd),
      .nvm_rdata_i(nadr[7:0] ^ 8'h5a));
   cpu_core_model i_cpu_core_model (.mclk_i(clk), .req_valid_o(req_valid), .req_o(req),
      .rsp_i(rsp));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (rsp.stall === 1'b1) stall_cyc++;
      if (pwe === 1'b1) last_pa = pa;
      if (nwr === 1'b1) nwr_seen = 1'b1;
      if (cyc == 3000) begin
         failures++;
         conclude();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic op(input data_space_pkg::op_type o, input logic [15:0] a, input logic [7:0] d,
      input logic [2:0] b = 3'h0, input data_space_pkg::addr_mode_type m = data_space_pkg::MODE_DIRECT,
      input data_space_pkg::ptr_sel_type p = data_space_pkg::PTR_NONE, input logic [5:0] s = 6'h00);
      i_cpu_core_model.access(data_space_pkg::cpu_req_type'{o, m, p, a, s, b, d}, rd, bv);
   endtask : op
   task automatic mw(input logic [15:0] a, input logic [7:0] d);
      op(data_space_pkg::OP_MEM_WRITE, a, d);
   endtask : mw
   task automatic iw(input logic [15:0] a, input logic [7:0] d);
      op(data_space_pkg::OP_IO_WRITE, a, d);
   endtask : iw
   task automatic mr(input logic [15:0] a, input logic [7:0] e, input string w);
      op(data_space_pkg::OP_MEM_READ, a, 8'h00);
      check(rd, e, w);
   endtask : mr
   task automatic ir(input logic [15:0] a, input logic [7:0] e, input string w);
      op(data_space_pkg::OP_IO_READ, a, 8'h00);
      check(rd, e, w);
   endtask : ir
   task automatic map_test;
      mr(16'h004a, 8'h00, "gpr at reset");
      mw(16'h004a, 8'ha5);
      ir(16'h002a, 8'ha5, "gpr by port");
      mw(16'h0005, 8'h3c);
      mr(16'h0005, 8'h3c, "work reg");
      mr(16'h0050, 8'h93, "std io read");
      iw(16'h0030, 8'h12);
      check(last_pa, 8'h50, "port write");
      mw(16'h0060, 8'h5e);
      check(last_pa, 8'h60, "ext io write");
      mr(16'h0600, 8'h00, "unmapped");
      mw(16'h0100, 8'h11);
      mw(16'h04ff, 8'h22);
      mr(16'h04ff, 8'h22, "sram top");
      mr(16'h0100, 8'h11, "sram base");
   endtask : map_test
   task automatic bits_test;
      iw(16'h001e, 8'h00);
      op(data_space_pkg::OP_SET_BIT, 16'h001e, 8'h00, 3'h3);
      ir(16'h001e, 8'h08, "bit set");
      op(data_space_pkg::OP_SKIP_TEST, 16'h001e, 8'h00, 3'h3);
      check({7'h00, bv}, 8'h01, "tested bit");
      op(data_space_pkg::OP_SET_BIT, 16'h002a, 8'h00, 3'h1);
      ir(16'h002a, 8'ha5, "bit op above 1f");
      flag_set <= 8'h81;
      @(posedge clk);
      flag_set <= 8'h00;
      op(data_space_pkg::OP_CLEAR_BIT, 16'h001d, 8'h00, 3'h0);
      check(flags, 8'h81, "bit clear keeps flags");
      iw(16'h001d, 8'h01);
      check(flags, 8'h80, "flag cleared by one");
   endtask : bits_test
   task automatic ptr_test;
      mw(16'h001a, 8'h00);
      mw(16'h001b, 8'h01);
      op(data_space_pkg::OP_MEM_WRITE, 16'h0000, 8'h77, 3'h0, data_space_pkg::MODE_POSTINC,
         data_space_pkg::PTR_X);
      mr(16'h001a, 8'h01, "x after inc");
      mr(16'h0100, 8'h77, "x target");
      op(data_space_pkg::OP_MEM_WRITE, 16'h0000, 8'h66, 3'h0, data_space_pkg::MODE_PREDEC,
         data_space_pkg::PTR_X);
      mr(16'h001a, 8'h00, "x after dec");
      mr(16'h0100, 8'h66, "x dec target");
      mw(16'h001c, 8'hff);
      mw(16'h001d, 8'h00);
      op(data_space_pkg::OP_MEM_WRITE, 16'h0000, 8'h44, 3'h0, data_space_pkg::MODE_DISP,
         data_space_pkg::PTR_Y, 6'h3f);
      mr(16'h013e, 8'h44, "y plus disp");
   endtask : ptr_test
   task automatic nvm_test;
      int n;
      int k;
      iw(16'h0021, 8'h37);
      iw(16'h0022, 8'h00);
      n = stall_cyc;
      iw(16'h001f, 8'h01);
      ir(16'h0020, 8'h6d, "nvm read data");
      check(8'(stall_cyc - n), 8'h04, "read stall");
      iw(16'h0020, 8'h99);
      check(nwd, 8'h99, "nvm write data");
      iw(16'h001f, 8'h04);
      n = stall_cyc;
      iw(16'h001f, 8'h02);
      op(data_space_pkg::OP_IO_READ, 16'h001f, 8'h00);
      check({7'h00, rd[1]}, 8'h01, "write busy");
      check(8'(stall_cyc - n), 8'h02, "write stall");
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      op(data_space_pkg::OP_IO_READ, 16'h001f, 8'h00);
      check({7'h00, rd[1]}, 8'h01, "busy over reset");
      k = 0;
      while (rd[1] !== 1'b0 && k < 20) begin
         op(data_space_pkg::OP_IO_READ, 16'h001f, 8'h00);
         k++;
      end
      check({7'h00, rd[1]}, 8'h00, "strobe cleared");
      check({7'h00, nwr_seen}, 8'h01, "array written");
   endtask : nvm_test
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   initial begin
      srst = 1'b1;
      flag_set = 8'h00;
      nwr_seen = 1'b0;
      last_pa = 8'h00;
      failures = 0;
      samples_checked = 0;
      cyc = 0;
      stall_cyc = 0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      map_test();
      bits_test();
      ptr_test();
      nvm_test();
      conclude();
   end
endmodule : data_space_decoder_tb
`default_nettype wire
